/* File: rtl/hrc_defines.svh */
// Constants for the hardware reset pin state control block.
`ifndef HRC_DEFINES_SVH
`define HRC_DEFINES_SVH
`define HRC_MIN_LOW_CYCLES 20
`define HRC_CNT_W 5
`define HRC_VEC_W 20
`define HRC_RESET_VECTOR 20'hFFFFC
`define HRC_BCLK_DIV 2
`endif

/* File: rtl/hrc_pkg.sv */
// Types for the hardware reset pin state control block.
package hrc_pkg;
  typedef enum logic [1:0]
  {
    HRC_RUN,
    HRC_HOLD,
    HRC_FETCH
  } hrc_state_t;
  // One pin group: output value, output enable (low drives), pull-up on.
  typedef struct packed
  {
    logic [7:0] out;
    logic [7:0] oe_n;
    logic [7:0] pull;
  } hrc_pins_t;
  // Bus strobes: value and enable, enable low while driven.
  typedef struct packed
  {
    logic first_chip_select;
    logic wr;
    logic rd;
    logic ale;
    logic bclk;
    logic high_byte_enable;
    logic bus_release_acknowledge;
  } hrc_strobe_t;
endpackage : hrc_pkg

/* File: rtl/hrc_low_filter.sv */
// Reset pin qualifier: synchroniser plus consecutive low counter.
`timescale 1ns/1ps
`include "hrc_defines.svh"
module hrc_low_filter #(
  parameter int MIN_LOW = `HRC_MIN_LOW_CYCLES
)(
  input wire logic core_clk_in,
  input wire logic rst_n_in,
  input wire logic pin_in,
  output logic qualified_out
);
  localparam int CW = $clog2(MIN_LOW + 1);
  logic sync1_r;
  logic sync2_r;
  logic [CW-1:0] cnt_r;
  // A zero threshold would let any glitch reset the device.
  if (MIN_LOW < 1)
  begin : g_bad_min_low
    $error("MIN_LOW must be at least one");
  end
  // ==========================================================
  // Synchroniser.
  always_ff @(posedge core_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      sync1_r <= 1'h1;
      sync2_r <= 1'h1;
    end
    else
    begin
      sync1_r <= pin_in;
      sync2_r <= sync1_r;
    end
  end
  // ==========================================================
  // Count consecutive low samples; a high sample restarts the count.
  always_ff @(posedge core_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      cnt_r <= '0;
    else if (sync2_r)
      cnt_r <= '0;
    else if (cnt_r != CW'(MIN_LOW))
      cnt_r <= cnt_r + CW'(1);
  end
  assign qualified_out = (cnt_r == CW'(MIN_LOW));
  // The count lags the synchroniser by one edge, so look one sample back.
  a_qual_needs_low: assert property (@(posedge core_clk_in)
    disable iff (!rst_n_in) qualified_out |-> $past(!sync2_r))
    else $error("reset qualified without a low sample");
endmodule : hrc_low_filter

/* File: rtl/hrc_reset_ctrl.sv */
// Reset qualifier, restart sequencer and pin states held during reset.
// Functional notes
// - On release, leave reset and fetch from the reset vector address.
// - Software reset behaves exactly like a hardware reset.
// - Reset aborts an in-flight RAM write; RAM is never initialised.
// - Single-chip mode in reset: all port pins floating inputs.
// - Processor mode: data pins float, address pins drive undefined values.
// - Processor mode: chip select, write, read strobes driven high.
// - Processor mode: latch enable low, bus clock runs, byte enable undefined.
// - Hold request and ready float; in processor mode acknowledge follows hold request.
// - Processor mode: upper three address/select pins float with pull-ups.
`timescale 1ns/1ps
`include "hrc_defines.svh"
module hrc_reset_ctrl #(
  parameter int MIN_LOW = `HRC_MIN_LOW_CYCLES,
  parameter int BCLK_DIV = `HRC_BCLK_DIV
)(
  input wire logic core_clk_in,
  input wire logic rst_n_in,
  input wire logic reset_pin_n_in,
  input wire logic sw_reset_in,
  input wire logic processor_mode_strap_in,
  input wire logic bus_width_8_in,
  input wire logic hold_request_in,
  input wire logic cpu_ram_we_in,
  input wire logic [`HRC_VEC_W-1:0] reset_vector_in,
  input wire logic fetch_ack_in,
  output logic cpu_reset_out,
  output logic ram_we_out,
  output logic fetch_req_out,
  output logic [`HRC_VEC_W-1:0] fetch_addr_out,
  output logic pin_override_out,
  output hrc_pkg::hrc_pins_t data_lo_out,
  output hrc_pkg::hrc_pins_t data_hi_out,
  output hrc_pkg::hrc_pins_t addr_lo_out,
  output hrc_pkg::hrc_pins_t addr_hi_out,
  output hrc_pkg::hrc_pins_t addr_top_out,
  output hrc_pkg::hrc_pins_t gen_port_out,
  output hrc_pkg::hrc_strobe_t strobe_out,
  output hrc_pkg::hrc_strobe_t strobe_oe_n_out
);
  localparam int DW = $clog2(BCLK_DIV + 1);
  hrc_pkg::hrc_state_t state_r;
  logic hw_low;
  logic sw_req_r;
  logic in_reset;
  logic bclk_r;
  logic [DW-1:0] div_r;
  logic mproc_r;
  logic byte8_r;
  logic [`HRC_VEC_W-1:0] addr_r;
  if (BCLK_DIV < 1)
  begin : g_bad_div
    $error("BCLK_DIV must be at least one");
  end

  // ==========================================================
  // Qualification of the reset pin.
  hrc_low_filter #(
    .MIN_LOW(MIN_LOW)
  ) u_filter (
    .core_clk_in(core_clk_in),
    .rst_n_in(rst_n_in),
    .pin_in(reset_pin_n_in),
    .qualified_out(hw_low)
  );

  // ==========================================================
  // Sequencer. Software reset enters the same HOLD state as the pin,
  // so the internal state after either is identical.
  always_ff @(posedge core_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      sw_req_r <= 1'h0;
    else
      sw_req_r <= sw_reset_in && (state_r == hrc_pkg::HRC_RUN);
  end

  always_ff @(posedge core_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      state_r <= hrc_pkg::HRC_HOLD;
    else
    begin
      case (state_r)
        hrc_pkg::HRC_RUN:
          if (hw_low || sw_req_r)
            state_r <= hrc_pkg::HRC_HOLD;
        hrc_pkg::HRC_HOLD:
          if (!hw_low)
            state_r <= hrc_pkg::HRC_FETCH;
        hrc_pkg::HRC_FETCH:
          if (hw_low)
            state_r <= hrc_pkg::HRC_HOLD;
          else if (fetch_ack_in)
            state_r <= hrc_pkg::HRC_RUN;
        default:
          state_r <= hrc_pkg::HRC_HOLD;
      endcase
    end
  end

  assign in_reset = (state_r == hrc_pkg::HRC_HOLD);
  assign cpu_reset_out = (state_r != hrc_pkg::HRC_RUN);
  assign fetch_req_out = (state_r == hrc_pkg::HRC_FETCH);
  // The write is cut at once; the cell may keep a partial value.
  assign ram_we_out = cpu_ram_we_in && !hw_low && !cpu_reset_out;
  assign pin_override_out = in_reset;

  // ==========================================================
  // Vector address latched while reset is held.
  always_ff @(posedge core_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      addr_r <= `HRC_RESET_VECTOR;
    else if (in_reset)
      addr_r <= reset_vector_in;
  end
  assign fetch_addr_out = addr_r;

  // ==========================================================
  // Straps followed every cycle while in reset.
  always_ff @(posedge core_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      mproc_r <= 1'h0;
      byte8_r <= 1'h0;
    end
    else if (in_reset)
    begin
      mproc_r <= processor_mode_strap_in;
      byte8_r <= bus_width_8_in;
    end
  end

  // ==========================================================
  // Bus clock divider; keeps running through reset.
  always_ff @(posedge core_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      div_r <= '0;
      bclk_r <= 1'h0;
    end
    else if (div_r == DW'(BCLK_DIV - 1))
    begin
      div_r <= '0;
      bclk_r <= !bclk_r;
    end
    else
      div_r <= div_r + DW'(1);
  end

  // ==========================================================
  // Pin states during reset. Undefined outputs are driven as zero.
  localparam hrc_pkg::hrc_pins_t FLOAT = '{8'h00, 8'hFF, 8'h00};
  localparam hrc_pkg::hrc_pins_t DRIVE0 = '{8'h00, 8'h00, 8'h00};
  always_comb
  begin
    data_lo_out = FLOAT;
    data_hi_out = FLOAT;
    addr_lo_out = FLOAT;
    addr_hi_out = FLOAT;
    addr_top_out = FLOAT;
    gen_port_out = FLOAT;
    strobe_out = '0;
    strobe_oe_n_out = '1;
    if (in_reset && mproc_r)
    begin
      addr_lo_out = DRIVE0;
      addr_hi_out = DRIVE0;
      addr_top_out = '{8'h00, 8'hF0, 8'hE0};
      strobe_out.first_chip_select = 1'h1;
      strobe_out.wr = 1'h1;
      strobe_out.rd = 1'h1;
      strobe_out.ale = 1'h0;
      strobe_out.bclk = bclk_r;
      strobe_out.high_byte_enable = 1'h0;
      strobe_out.bus_release_acknowledge = hold_request_in;
      strobe_oe_n_out = '0;
    end
  end

  a_cs_high: assert property (@(posedge core_clk_in)
    disable iff (!rst_n_in) (in_reset && mproc_r) |->
    (strobe_out.first_chip_select && strobe_out.wr && strobe_out.rd
    && !strobe_oe_n_out.rd))
    else $error("bus strobes not held high during reset");
  a_single_float: assert property (@(posedge core_clk_in)
    disable iff (!rst_n_in) (in_reset && !mproc_r) |->
    (&addr_lo_out.oe_n && &data_lo_out.oe_n && &strobe_oe_n_out))
    else $error("single-chip pins not floating during reset");
  a_ale_low: assert property (@(posedge core_clk_in)
    disable iff (!rst_n_in) (in_reset && mproc_r) |->
    (!strobe_out.ale && !strobe_oe_n_out.ale))
    else $error("latch enable not driven low during reset");
  a_ack_follows: assert property (@(posedge core_clk_in)
    disable iff (!rst_n_in) (in_reset && mproc_r) |->
    (strobe_out.bus_release_acknowledge == hold_request_in))
    else $error("hold acknowledge does not follow hold request");
  a_pullup_top: assert property (@(posedge core_clk_in)
    disable iff (!rst_n_in) (in_reset && mproc_r) |->
    (addr_top_out.pull[7:5] == 3'h7 && addr_top_out.oe_n[7:5] == 3'h7))
    else $error("upper select pins lack pull-ups during reset");
  a_addr_driven: assert property (@(posedge core_clk_in)
    disable iff (!rst_n_in) (in_reset && mproc_r) |->
    (addr_lo_out.oe_n == 8'h00 && data_hi_out.oe_n == 8'hFF))
    else $error("address pins not driven during reset");
  // On the narrow bus the high data byte is a plain input, still floating.
  a_data_hi_float: assert property (@(posedge core_clk_in)
    disable iff (!rst_n_in) (in_reset && mproc_r && byte8_r) |->
    (data_hi_out.oe_n == 8'hFF && data_lo_out.oe_n == 8'hFF))
    else $error("data pins not floating on the narrow bus");
  a_release_fetch: assert property (@(posedge core_clk_in)
    disable iff (!rst_n_in) (in_reset && !hw_low) |=>
    (fetch_req_out && fetch_addr_out == $past(reset_vector_in)))
    else $error("release did not fetch from the reset vector");
  // A held request re-arms the flag once; only its first cycle counts.
  a_sw_like_hw: assert property (@(posedge core_clk_in)
    disable iff (!rst_n_in) (state_r == hrc_pkg::HRC_RUN && sw_reset_in
    && !sw_req_r && !hw_low) |-> ##2 in_reset)
    else $error("software reset did not enter the hold state");
  a_ram_cut: assert property (@(posedge core_clk_in)
    disable iff (!rst_n_in) cpu_reset_out |-> !ram_we_out)
    else $error("RAM write passed during reset");
  a_strap_track: assert property (@(posedge core_clk_in)
    disable iff (!rst_n_in) (in_reset ##1 in_reset) |->
    (mproc_r == $past(processor_mode_strap_in)
    && byte8_r == $past(bus_width_8_in)))
    else $error("straps not followed during reset");
  c_hw_reset: cover property (@(posedge core_clk_in)
    disable iff (!rst_n_in) $rose(hw_low));
  c_sw_reset: cover property (@(posedge core_clk_in)
    disable iff (!rst_n_in) sw_req_r);
  c_fetch: cover property (@(posedge core_clk_in)
    disable iff (!rst_n_in) fetch_req_out && fetch_ack_in);
  c_mproc: cover property (@(posedge core_clk_in)
    disable iff (!rst_n_in) in_reset && mproc_r);
endmodule : hrc_reset_ctrl

/* File: verif/hrc_ext_model.sv */
// External reset source and bus hold requester seen by the block.
`timescale 1ns/1ps
module hrc_ext_model (
  input wire logic core_clk_in,
  output logic reset_pin_n_out,
  output logic hold_request_out
);
  initial
  begin
    reset_pin_n_out = 1'b1;
    hold_request_out = 1'b0;
  end
  // One call holds the level for one cycle, so a reset needs MIN_LOW calls.
  task set_pin(input logic v);
    @(posedge core_clk_in);
    reset_pin_n_out <= v;
  endtask : set_pin
  task set_hold(input logic v);
    @(posedge core_clk_in);
    hold_request_out <= v;
  endtask : set_hold
endmodule : hrc_ext_model

/* File: verif/tb.sv */
// Self-checking testbench for the reset pin state control block.
`timescale 1ns/1ps
module tb;
  localparam int MIN_LOW = 3;
  logic core_clk_in = 1'b0;
  logic rst_n_in;
  logic sw_reset;
  logic strap;
  logic bw8;
  logic ram_we;
  logic fetch_ack;
  logic [19:0] vec;
  logic pin_n, hold_req, cpu_reset, ram_we_o, fetch_req, override;
  logic [19:0] fetch_addr;
  hrc_pkg::hrc_pins_t d_lo, d_hi, a_lo, a_hi, a_top, gen;
  hrc_pkg::hrc_strobe_t stb, stb_oe_n;
  int fails = 0;
  int num_checks = 0;
  always #2.5 core_clk_in = ~core_clk_in;
  hrc_ext_model ext (.core_clk_in(core_clk_in), .reset_pin_n_out(pin_n),
    .hold_request_out(hold_req));
  hrc_reset_ctrl #(.MIN_LOW(MIN_LOW)) uut (.core_clk_in(core_clk_in),
    .rst_n_in(rst_n_in), .reset_pin_n_in(pin_n), .sw_reset_in(sw_reset),
    .processor_mode_strap_in(strap), .bus_width_8_in(bw8),
    .hold_request_in(hold_req), .cpu_ram_we_in(ram_we),
    .reset_vector_in(vec), .fetch_ack_in(fetch_ack),
    .cpu_reset_out(cpu_reset), .ram_we_out(ram_we_o),
    .fetch_req_out(fetch_req), .fetch_addr_out(fetch_addr),
    .pin_override_out(override), .data_lo_out(d_lo), .data_hi_out(d_hi),
    .addr_lo_out(a_lo), .addr_hi_out(a_hi), .addr_top_out(a_top),
    .gen_port_out(gen), .strobe_out(stb), .strobe_oe_n_out(stb_oe_n));
  // ==========================================================
  // Shared helpers
  task results;
    if (fails == 0 && num_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : results
  task chk(input string what, input logic [63:0] exp, input logic [63:0] got);
    num_checks++;
    if (got !== exp)
    begin
      fails++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  // Bounded wait on the hold state or on the first fetch request.
  task wait_on(input bit fetch);
    int n;
    n = 0;
    @(negedge core_clk_in);
    while ((fetch ? fetch_req : override) !== 1'h1)
    begin
      n++;
      if (n > 60)
      begin
        fails++;
        results();
      end
      @(negedge core_clk_in);
    end
  endtask : wait_on
  task finish_fetch(input logic [19:0] exp);
    wait_on(1'b1);
    chk("fetch_addr", exp, fetch_addr);
    @(posedge core_clk_in);
    fetch_ack <= 1'b1;
    @(posedge core_clk_in);
    fetch_ack <= 1'b0;
    @(negedge core_clk_in);
    chk("cpu_reset", 0, cpu_reset);
  endtask : finish_fetch
  // ==========================================================
  // Scenarios
  task short_pulse;
    repeat (MIN_LOW - 1) ext.set_pin(1'b0);
    ext.set_pin(1'b1);
    repeat (10)
    begin
      @(negedge core_clk_in);
      chk("cpu_reset short", 0, cpu_reset);
    end
  endtask : short_pulse
  task hw_reset(input logic mode, input logic w8);
    logic b0;
    @(posedge core_clk_in);
    strap <= mode;
    bw8 <= w8;
    repeat (MIN_LOW + 4) ext.set_pin(1'b0);
    wait_on(1'b0);
    @(negedge core_clk_in);
    chk("override", 1, override);
    if (mode)
    begin
      chk("oe_n", 48'hFFFF0000F0FF, {d_lo.oe_n, d_hi.oe_n, a_lo.oe_n,
        a_hi.oe_n, a_top.oe_n, gen.oe_n});
      chk("top pull", 3'h7, a_top.pull[7:5]);
      chk("strobes", 4'hE, stb[6:3]);
      chk("strobe_oe_n", 7'h00, stb_oe_n);
      b0 = stb.bclk;
      repeat (2) @(negedge core_clk_in);
      chk("bclk", !b0, stb.bclk);
      ext.set_hold(1'b1);
      repeat (3) @(negedge core_clk_in);
      chk("hold ack", 1, stb.bus_release_acknowledge);
      ext.set_hold(1'b0);
      repeat (3) @(negedge core_clk_in);
      chk("hold ack", 0, stb.bus_release_acknowledge);
      @(posedge core_clk_in);
      strap <= 1'h0;
      repeat (3) @(negedge core_clk_in);
      chk("strap track", 8'hFF, a_lo.oe_n);
    end
    else
    begin
      chk("oe_n", 48'hFFFFFFFFFFFF, {d_lo.oe_n, d_hi.oe_n, a_lo.oe_n,
        a_hi.oe_n, a_top.oe_n, gen.oe_n});
      chk("strobe_oe_n", 7'h7F, stb_oe_n);
    end
    @(posedge core_clk_in);
    ram_we <= 1'h1;
    @(negedge core_clk_in);
    chk("ram_we held", 0, ram_we_o);
    ext.set_pin(1'b1);
    finish_fetch(vec);
    chk("ram_we run", 1, ram_we_o);
    @(posedge core_clk_in);
    ram_we <= 1'h0;
  endtask : hw_reset
  task sw_reset_run;
    @(posedge core_clk_in);
    vec <= 20'h0F0F0;
    sw_reset <= 1'b1;
    @(posedge core_clk_in);
    sw_reset <= 1'b0;
    // The request is registered first, so hold is entered one edge later.
    repeat (2) @(negedge core_clk_in);
    chk("cpu_reset sw", 1, cpu_reset);
    finish_fetch(20'h0F0F0);
  endtask : sw_reset_run
  initial
  begin
    rst_n_in <= 1'h0;
    sw_reset <= 1'h0;
    strap <= 1'h0;
    bw8 <= 1'h0;
    ram_we <= 1'h0;
    fetch_ack <= 1'h0;
    vec <= 20'h1A2B4;
    repeat (4) @(posedge core_clk_in);
    rst_n_in <= 1'b1;
    finish_fetch(20'h1A2B4);
    short_pulse();
    hw_reset(1'b0, 1'b0);
    hw_reset(1'b1, 1'b0);
    hw_reset(1'b1, 1'b1);
    sw_reset_run();
    results();
  end
endmodule : tb
